// >>> src/boot_cfg_pkg.sv
// Constants, field layout and register map for the boot configuration decoder.
// Assumes a 32-bit AXI4-Lite register bus and a 14-bit nonvolatile word.
package boot_cfg_pkg;

    localparam int CFG_WIDTH = 14;
    localparam int AXI_ADDR_WIDTH = 12;
    localparam int AXI_DATA_WIDTH = 32;

    // Field positions inside the configuration word
    localparam int FLD_FAIL_SAFE = 13;
    localparam int FLD_CLOCK_OUT_GATE = 11;
    localparam int FLD_RESET_PIN_SEL = 6;
    localparam int FLD_POWERUP_TIMER_N = 5;
    localparam int FLD_WDT_POLICY_HI = 4;
    localparam int FLD_WDT_POLICY_LO = 3;
    localparam int FLD_OSC_HI = 2;
    localparam int FLD_OSC_LO = 0;

    // Watchdog policy codes
    localparam logic [1:0] WDT_ALWAYS = 2'h3;
    localparam logic [1:0] WDT_RUN_ONLY = 2'h2;
    localparam logic [1:0] WDT_SOFTWARE = 2'h1;

    // Oscillator select codes
    localparam logic [2:0] OSC_EXT_HIGH = 3'h7;
    localparam logic [2:0] OSC_EXT_MEDIUM = 3'h6;
    localparam logic [2:0] OSC_EXT_LOW = 3'h5;
    localparam logic [2:0] OSC_INTERNAL = 3'h4;
    localparam logic [2:0] OSC_EXT_RC = 3'h3;
    localparam logic [2:0] OSC_FAST_XTAL = 3'h2;
    localparam logic [2:0] OSC_STD_XTAL = 3'h1;

    // Value of an erased word, held until the real word is caught
    localparam logic [13:0] CFG_ERASED = 14'h3FFF;

    // Register byte offsets
    localparam logic [11:0] OFS_CONFIG_WORD = 12'h000;
    localparam logic [11:0] OFS_WDT_CONTROL = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // Watchdog control register layout and reset value
    localparam int WDT_CTL_SW_ON = 0;
    localparam logic WDT_CTL_RESET = 1'h0;

    // Status register layout
    localparam int ST_LOADED = 0;
    localparam int ST_WDT_RUN = 1;
    localparam int ST_POWERUP_TIMER_ON = 2;
    localparam int ST_MASTER_RESET_INPUT_ON = 3;
    localparam int ST_PULLUP_ON = 4;
    localparam int ST_CLOCK_OUTPUT_PIN_ON = 5;
    localparam int ST_FAIL_SAFE = 6;
    localparam int ST_CRYSTAL = 7;
    localparam int ST_OSC_LO = 8;

    // Sync stages to fill before the word is trusted
    localparam int SYNC_STAGES = 3;
    localparam logic [1:0] SYNC_FILL_CYCLES = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        LOAD_FILL = 3'b001,
        LOAD_CAPTURE = 3'b010,
        LOAD_HOLD = 3'b100
    } load_state_e;

endpackage : boot_cfg_pkg

// >>> src/pin_sync3.sv
// Three-stage synchroniser for a bus of pin-level inputs.
// Assumes the bits are quasi-static; stage one feeds stage two only.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 14
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stage_two,
    output logic [WIDTH-1:0] stage_three
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage_one;
            logic s2;
            logic s3;
            always_ff @(posedge clk) begin
                if (ce) begin
                    stage_one <= async_in[i];
                    s2 <= stage_one;
                    s3 <= s2;
                end
            end
            assign stage_two[i] = s2;
            assign stage_three[i] = s3;
        end
    endgenerate
endmodule : pin_sync3

// >>> src/boot_config_word_decode.sv
// Boot configuration word decoder with an AXI4-Lite register slave.
// Assumes rst is the power-on reset and the word is static after power-up.
`timescale 1ns/1ps
module boot_config_word_decode
    import boot_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [boot_cfg_pkg::CFG_WIDTH-1:0] config_word_pins,
    input wire logic low_voltage_programming,
    input wire logic core_in_sleep,
    input wire logic port_pullup_request,
    input wire logic [boot_cfg_pkg::AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [boot_cfg_pkg::AXI_DATA_WIDTH-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [boot_cfg_pkg::AXI_ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [boot_cfg_pkg::AXI_DATA_WIDTH-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic config_loaded,
    output logic watchdog_timer_run,
    output logic [2:0] oscillator_select_field,
    output logic [6:0] oscillator_mode_onehot,
    output logic oscillator_uses_crystal_pins,
    output logic powerup_timer_on,
    output logic master_reset_input_on,
    output logic reset_pin_pullup_on,
    output logic clock_output_pin_on,
    output logic fail_safe_monitor_on
);
    import boot_cfg_pkg::*;

    // Crystal modes take over the clock-output pin
    function automatic logic is_crystal(input logic [2:0] osc);
        is_crystal = (osc == OSC_FAST_XTAL) || (osc == OSC_STD_XTAL);
    endfunction : is_crystal

    // One-hot mode vector, bit n set for code n+1
    function automatic logic [6:0] osc_onehot(input logic [2:0] osc);
        logic [6:0] v;
        v = 7'h00;
        case (osc)
            OSC_EXT_HIGH: v = 7'h40;
            OSC_EXT_MEDIUM: v = 7'h20;
            OSC_EXT_LOW: v = 7'h10;
            OSC_INTERNAL: v = 7'h08;
            OSC_EXT_RC: v = 7'h04;
            OSC_FAST_XTAL: v = 7'h02;
            OSC_STD_XTAL: v = 7'h01;
            default: v = 7'h00;
        endcase
        osc_onehot = v;
    endfunction : osc_onehot

    // Register offset decode shared by read and write paths
    function automatic logic [2:0] reg_hit(input logic [AXI_ADDR_WIDTH-1:0] a);
        reg_hit = {a == OFS_STATUS, a == OFS_WDT_CONTROL, a == OFS_CONFIG_WORD};
    endfunction : reg_hit

    // Pin synchroniser
    logic [CFG_WIDTH-1:0] word_s2;
    logic [CFG_WIDTH-1:0] word_s3;
    logic lvp_s2;
    logic lvp_s3;

    pin_sync3 #(
        .WIDTH(CFG_WIDTH + 1)
    ) u_sync (
        .clk(clk),
        .ce(ce),
        .async_in({low_voltage_programming, config_word_pins}),
        .stage_two({lvp_s2, word_s2}),
        .stage_three({lvp_s3, word_s3})
    );

    // Capture sequencer
    load_state_e load_state;
    load_state_e next_load_state;
    logic [1:0] fill_count;
    logic [1:0] next_fill_count;
    logic [CFG_WIDTH-1:0] cfg_word;
    logic [CFG_WIDTH-1:0] next_cfg_word;
    logic lvp_latched;
    logic next_lvp_latched;

    always_comb begin
        next_load_state = load_state;
        next_fill_count = fill_count;
        next_cfg_word = cfg_word;
        next_lvp_latched = lvp_latched;
        case (load_state)
            LOAD_FILL: begin
                next_fill_count = fill_count + 2'h1;
                if (fill_count == SYNC_FILL_CYCLES - 2'h1) begin
                    next_load_state = LOAD_CAPTURE;
                end
            end
            LOAD_CAPTURE: begin
                if ((word_s2 == word_s3) && (lvp_s2 == lvp_s3)) begin
                    next_cfg_word = word_s3;
                    next_lvp_latched = lvp_s3;
                    next_load_state = LOAD_HOLD;
                end
            end
            LOAD_HOLD: begin
                next_load_state = LOAD_HOLD;
            end
            default: begin
                next_load_state = LOAD_FILL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            load_state <= LOAD_FILL;
            fill_count <= 2'h0;
            cfg_word <= CFG_ERASED;
            lvp_latched <= 1'b0;
        end else if (ce) begin
            load_state <= next_load_state;
            fill_count <= next_fill_count;
            cfg_word <= next_cfg_word;
            lvp_latched <= next_lvp_latched;
        end
    end

    // Decoded controls
    logic loaded;
    logic sw_watchdog_on;
    logic [1:0] wdt_policy;
    logic [2:0] osc_sel;
    logic next_loaded;
    logic next_wdt_run;
    logic next_powerup_timer_on;
    logic next_master_reset_input_on;
    logic next_pullup_on;
    logic next_clock_output_pin_on;
    logic next_fcm_on;
    logic next_crystal;
    logic [2:0] next_osc_sel;
    logic [6:0] next_osc_onehot;

    assign loaded = (load_state == LOAD_HOLD);
    assign wdt_policy = cfg_word[FLD_WDT_POLICY_HI:FLD_WDT_POLICY_LO];
    assign osc_sel = cfg_word[FLD_OSC_HI:FLD_OSC_LO];

    always_comb begin
        next_loaded = loaded;
        next_wdt_run = 1'b0;
        next_powerup_timer_on = 1'b0;
        next_master_reset_input_on = 1'b0;
        next_pullup_on = 1'b0;
        next_clock_output_pin_on = 1'b0;
        next_fcm_on = 1'b0;
        next_crystal = 1'b0;
        next_osc_sel = 3'h0;
        next_osc_onehot = 7'h00;
        if (loaded) begin
            case (wdt_policy)
                WDT_ALWAYS: next_wdt_run = 1'b1;
                WDT_RUN_ONLY: next_wdt_run = !core_in_sleep;
                WDT_SOFTWARE: next_wdt_run = sw_watchdog_on;
                default: next_wdt_run = 1'b0;
            endcase
            next_osc_sel = osc_sel;
            next_osc_onehot = osc_onehot(osc_sel);
            next_crystal = is_crystal(osc_sel);
            next_powerup_timer_on = !cfg_word[FLD_POWERUP_TIMER_N];
            if (lvp_latched || cfg_word[FLD_RESET_PIN_SEL]) begin
                next_master_reset_input_on = 1'b1;
                next_pullup_on = 1'b1;
            end else begin
                next_master_reset_input_on = 1'b0;
                next_pullup_on = port_pullup_request;
            end
            next_clock_output_pin_on = !is_crystal(osc_sel) && !cfg_word[FLD_CLOCK_OUT_GATE];
            next_fcm_on = cfg_word[FLD_FAIL_SAFE];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            config_loaded <= 1'b0;
            watchdog_timer_run <= 1'b0;
            powerup_timer_on <= 1'b0;
            master_reset_input_on <= 1'b0;
            reset_pin_pullup_on <= 1'b0;
            clock_output_pin_on <= 1'b0;
            fail_safe_monitor_on <= 1'b0;
            oscillator_uses_crystal_pins <= 1'b0;
            oscillator_select_field <= 3'h0;
            oscillator_mode_onehot <= 7'h00;
        end else if (ce) begin
            config_loaded <= next_loaded;
            watchdog_timer_run <= next_wdt_run;
            powerup_timer_on <= next_powerup_timer_on;
            master_reset_input_on <= next_master_reset_input_on;
            reset_pin_pullup_on <= next_pullup_on;
            clock_output_pin_on <= next_clock_output_pin_on;
            fail_safe_monitor_on <= next_fcm_on;
            oscillator_uses_crystal_pins <= next_crystal;
            oscillator_select_field <= next_osc_sel;
            oscillator_mode_onehot <= next_osc_onehot;
        end
    end

    // AXI4-Lite write path
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_WIDTH-1:0] aw_addr;
    logic [AXI_DATA_WIDTH-1:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [AXI_ADDR_WIDTH-1:0] next_aw_addr;
    logic [AXI_DATA_WIDTH-1:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_sw_watchdog_on;
    logic [2:0] w_hit;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign w_hit = reg_hit(aw_addr);

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_sw_watchdog_on = sw_watchdog_on;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (w_hit[1]) begin
                if (w_strb[0]) begin
                    next_sw_watchdog_on = w_data[WDT_CTL_SW_ON];
                end
            end else if (!w_hit[0] && !w_hit[2]) begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            sw_watchdog_on <= WDT_CTL_RESET;
        end else if (ce) begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            sw_watchdog_on <= next_sw_watchdog_on;
        end
    end

    // AXI4-Lite read path
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [AXI_DATA_WIDTH-1:0] next_rdata;
    logic [AXI_DATA_WIDTH-1:0] status_word;
    logic [2:0] r_hit;

    assign s_axi_arready = !s_axi_rvalid;
    assign r_hit = reg_hit(s_axi_araddr);

    always_comb begin
        status_word = '0;
        status_word[ST_LOADED] = config_loaded;
        status_word[ST_WDT_RUN] = watchdog_timer_run;
        status_word[ST_POWERUP_TIMER_ON] = powerup_timer_on;
        status_word[ST_MASTER_RESET_INPUT_ON] = master_reset_input_on;
        status_word[ST_PULLUP_ON] = reset_pin_pullup_on;
        status_word[ST_CLOCK_OUTPUT_PIN_ON] = clock_output_pin_on;
        status_word[ST_FAIL_SAFE] = fail_safe_monitor_on;
        status_word[ST_CRYSTAL] = oscillator_uses_crystal_pins;
        status_word[ST_OSC_LO +: 3] = oscillator_select_field;
    end

    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            case (r_hit)
                3'b001: next_rdata[CFG_WIDTH-1:0] = cfg_word;
                3'b010: next_rdata[WDT_CTL_SW_ON] = sw_watchdog_on;
                3'b100: next_rdata = status_word;
                default: next_rresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else if (ce) begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

endmodule : boot_config_word_decode

// >>> bench/boot_config_word_decode_properties.sv
// Checker of the boot configuration decoder, bound to its top module.
// Assumes the word and the programming pin stay put until the word is loaded.
`timescale 1ns/1ps
module boot_config_word_decode_properties
    import boot_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [boot_cfg_pkg::CFG_WIDTH-1:0] config_word_pins,
    input wire logic low_voltage_programming,
    input wire logic core_in_sleep,
    input wire logic s_axi_bvalid,
    input wire logic config_loaded,
    input wire logic watchdog_timer_run,
    input wire logic [2:0] oscillator_select_field,
    input wire logic [6:0] oscillator_mode_onehot,
    input wire logic oscillator_uses_crystal_pins,
    input wire logic powerup_timer_on,
    input wire logic master_reset_input_on,
    input wire logic reset_pin_pullup_on,
    input wire logic clock_output_pin_on,
    input wire logic fail_safe_monitor_on
);
    import boot_cfg_pkg::*;
    logic seen;
    logic cap_lvp;
    logic [13:0] cap;
    logic [1:0] pol;
    logic xtal;
    logic [6:0] hot;
    logic [10:0] outs;

    // Copy of the word as it stood when loading finished
    always_ff @(posedge clk) begin
        if (rst) begin
            seen <= 1'b0;
        end else if (config_loaded && !seen) begin
            seen <= 1'b1;
            cap <= config_word_pins;
            cap_lvp <= low_voltage_programming;
        end
    end
    assign pol = cap[FLD_WDT_POLICY_HI:FLD_WDT_POLICY_LO];
    assign xtal = (cap[2:0] == OSC_FAST_XTAL) || (cap[2:0] == OSC_STD_XTAL);
    assign hot = (cap[2:0] == 3'h0) ? 7'h00 : 7'(7'h01 << (cap[2:0] - 3'h1));
    assign outs = {oscillator_select_field, oscillator_uses_crystal_pins, fail_safe_monitor_on,
        clock_output_pin_on, reset_pin_pullup_on, master_reset_input_on, powerup_timer_on,
        watchdog_timer_run, config_loaded};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_wdt_always;
        seen && pol == WDT_ALWAYS |=> watchdog_timer_run;
    endproperty
    a_wdt_always: assert property (p_wdt_always)
        else $error("watchdog stopped under always-on policy");
    property p_wdt_run_only;
        seen && ce && pol == WDT_RUN_ONLY |=> watchdog_timer_run == !$past(core_in_sleep);
    endproperty
    a_wdt_run_only: assert property (p_wdt_run_only)
        else $error("watchdog does not follow sleep state");
    property p_wdt_software;
        seen && pol == WDT_SOFTWARE && !s_axi_bvalid && !$past(s_axi_bvalid)
            |=> $stable(watchdog_timer_run);
    endproperty
    a_wdt_software: assert property (p_wdt_software)
        else $error("watchdog changed without a software write");
    property p_osc_decode;
        seen |-> oscillator_mode_onehot == hot && oscillator_select_field == cap[2:0];
    endproperty
    a_osc_decode: assert property (p_osc_decode)
        else $error("oscillator mode decode wrong");
    property p_crystal;
        seen |-> oscillator_uses_crystal_pins == xtal;
    endproperty
    a_crystal: assert property (p_crystal)
        else $error("crystal pin use wrong");
    property p_clock_output_pin;
        seen |-> clock_output_pin_on == (!xtal && !cap[FLD_CLOCK_OUT_GATE]);
    endproperty
    a_clock_output_pin: assert property (p_clock_output_pin)
        else $error("clock output gating wrong");
    property p_powerup_timer;
        seen |-> powerup_timer_on == !cap[FLD_POWERUP_TIMER_N];
    endproperty
    a_powerup_timer: assert property (p_powerup_timer)
        else $error("power-up timer polarity wrong");
    property p_lvp_pin;
        seen && cap_lvp |-> master_reset_input_on && reset_pin_pullup_on;
    endproperty
    a_lvp_pin: assert property (p_lvp_pin)
        else $error("reset pin not forced with low-voltage programming");
    property p_fail_safe;
        seen |-> fail_safe_monitor_on == cap[FLD_FAIL_SAFE];
    endproperty
    a_fail_safe: assert property (p_fail_safe)
        else $error("fail-safe monitor enable wrong");
    property p_hold;
        seen |=> $stable({outs[10:5], outs[3:2], outs[0], oscillator_mode_onehot});
    endproperty
    a_hold: assert property (p_hold)
        else $error("decoded output moved after loading");
    property p_quiet;
        !config_loaded |-> outs == 11'h000 && oscillator_mode_onehot == 7'h00;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("decoded output active before loading");
    property p_load_time;
        $fell(rst) |-> ##[1:30] config_loaded;
    endproperty
    a_load_time: assert property (p_load_time)
        else $error("word not loaded after reset");
endmodule : boot_config_word_decode_properties

bind boot_config_word_decode boot_config_word_decode_properties u_props (.clk, .rst, .ce,
    .config_word_pins, .low_voltage_programming, .core_in_sleep, .s_axi_bvalid, .config_loaded,
    .watchdog_timer_run, .oscillator_select_field, .oscillator_mode_onehot,
    .oscillator_uses_crystal_pins, .powerup_timer_on, .master_reset_input_on,
    .reset_pin_pullup_on, .clock_output_pin_on, .fail_safe_monitor_on);

// >>> bench/boot_config_word_decode_tb.sv
// Self-checking bench of the boot configuration decoder.
// Assumes the package and the bound checker are compiled alongside.
`timescale 1ns/1ps
module boot_config_word_decode_tb;
    import boot_cfg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, low_voltage_programming = 1'b0;
    logic core_in_sleep = 1'b0, port_pullup_request = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [13:0] config_word_pins = 14'h0000;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic config_loaded, watchdog_timer_run, oscillator_uses_crystal_pins, powerup_timer_on;
    logic master_reset_input_on, reset_pin_pullup_on, clock_output_pin_on, fail_safe_monitor_on;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] oscillator_select_field;
    logic [6:0] oscillator_mode_onehot;
    logic [10:0] outs;
    logic [13:0] word;
    logic lvp_v, pr_v, ld;
    int n_errors = 0;
    int compares = 0;
    int seed = 32'h93EA9415;

    boot_config_word_decode DUT (.clk, .rst, .ce, .config_word_pins, .low_voltage_programming,
        .core_in_sleep, .port_pullup_request, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_loaded, .watchdog_timer_run,
        .oscillator_select_field, .oscillator_mode_onehot, .oscillator_uses_crystal_pins,
        .powerup_timer_on, .master_reset_input_on, .reset_pin_pullup_on, .clock_output_pin_on,
        .fail_safe_monitor_on);
    assign outs = {oscillator_select_field, oscillator_uses_crystal_pins, fail_safe_monitor_on,
        clock_output_pin_on, reset_pin_pullup_on, master_reset_input_on, powerup_timer_on,
        watchdog_timer_run, config_loaded};

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Status word as the decode rules predict it
    function automatic logic [31:0] expect_status(input logic [13:0] w, input logic l,
        input logic p, input logic sw, input logic sl);
        logic xt, run, mr;
        xt = (w[2:0] == 3'h2) || (w[2:0] == 3'h1);
        run = (w[4:3] == 2'h3) || (w[4:3] == 2'h2 && !sl) || (w[4:3] == 2'h1 && sw);
        mr = l || w[6];
        return {21'h0, w[2:0], xt, w[13], !xt && !w[11], mr || p, mr, !w[5], run, 1'b1};
    endfunction : expect_status

    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int t = 0; t < 64 && !b; t++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("write response", {b, r}, {1'b1, er});
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ev, input logic [1:0] er);
        logic ar, b;
        logic [1:0] r;
        logic [31:0] v;
        b = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int t = 0; t < 64 && !b; t++) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("read response", {b, r}, {1'b1, er});
        chk("read data", v, ev);
        @(posedge clk);
    endtask : axi_read

    // Compares every decoded output against the held word
    task automatic look(input logic sw, input logic sl);
        @(negedge clk);
        chk("outputs", {21'h0, outs}, expect_status(word, lvp_v, pr_v, sw, sl));
        chk("onehot", {25'h0, oscillator_mode_onehot},
            (word[2:0] == 3'h0) ? 32'h0 : 32'h1 << (word[2:0] - 3'h1));
        @(posedge clk);
    endtask : look

    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            word = 14'($random(seed));
            word[2:0] = i[2:0];
            word[4:3] = i[3:2];
            lvp_v = i[1];
            pr_v = 1'($random(seed));
            config_word_pins <= word;
            low_voltage_programming <= lvp_v;
            port_pullup_request <= pr_v;
            core_in_sleep <= 1'b0;
            ce <= (i != 3);
            rst <= 1'b1;
            repeat (3) @(posedge clk);
            rst <= 1'b0;
            ce <= (i != 5);
            if (i == 5) begin
                repeat (4) @(posedge clk);
                ce <= 1'b1;
            end
            ld = 1'b0;
            for (int t = 0; t < 40 && !ld; t++) begin
                @(negedge clk);
                ld = config_loaded;
                @(posedge clk);
            end
            chk("loaded", {31'h0, ld}, 32'h1);
            look(1'b0, 1'b0);
            axi_read(OFS_CONFIG_WORD, {18'h0, word}, RESP_OKAY);
            axi_read(OFS_STATUS, expect_status(word, lvp_v, pr_v, 0, 0), RESP_OKAY);
            core_in_sleep <= 1'b1;
            repeat (2) @(posedge clk);
            look(1'b0, 1'b1);
            axi_write(OFS_WDT_CONTROL, 32'h1, RESP_OKAY);
            repeat (2) @(posedge clk);
            look(1'b1, 1'b1);
            axi_read(OFS_WDT_CONTROL, 32'h1, RESP_OKAY);
            core_in_sleep <= 1'b0;
            config_word_pins <= ~word;
            low_voltage_programming <= !lvp_v;
            axi_write(OFS_CONFIG_WORD, $random(seed), RESP_OKAY);
            axi_write(12'h00C | 12'(i << 4), 32'h1, RESP_SLVERR);
            axi_read(12'h00C | 12'(i << 4), 32'h0, RESP_SLVERR);
            look(1'b1, 1'b0);
            axi_read(OFS_CONFIG_WORD, {18'h0, word}, RESP_OKAY);
        end
        wrap_up();
    end
endmodule : boot_config_word_decode_tb
